// file: smwsp_cfg.svh
// timing, encoding and reset constants of the static memory access sequencer
`ifndef SMWSP_CFG_SVH
`define SMWSP_CFG_SVH

// external wait mode encodings
`define SMWSP_WAIT_OFF      2'h0
`define SMWSP_WAIT_FROZEN   2'h2
`define SMWSP_WAIT_READY    2'h3

// fixed slow clock read waveform, in cycles
`define SMWSP_SLOW_RD_SETUP    10'h001
`define SMWSP_SLOW_RD_PULSE    10'h001
`define SMWSP_SLOW_CS_RD_SETUP 10'h000
`define SMWSP_SLOW_CS_RD_PULSE 10'h002
`define SMWSP_SLOW_RD_CYCLE    10'h002

// fixed slow clock write waveform, in cycles
`define SMWSP_SLOW_WR_SETUP    10'h001
`define SMWSP_SLOW_WR_PULSE    10'h001
`define SMWSP_SLOW_CS_WR_SETUP 10'h000
`define SMWSP_SLOW_CS_WR_PULSE 10'h003
`define SMWSP_SLOW_WR_CYCLE    10'h003

// smallest page is 4 bytes, so the offset field is at least 2 bits
`define SMWSP_PAGE_LOG2_MIN 5'h02

// data bus width codes
`define SMWSP_DBW_16 2'h1
`define SMWSP_DBW_32 2'h2

// reset values
`define SMWSP_HOLD_IDLE   1'h1
`define SMWSP_CNT_RESET   10'h000
`define SMWSP_ADDR_RESET  26'h0000000
`define SMWSP_OFF_RESET   5'h00
`define SMWSP_CS_RESET    3'h0

`endif

// file: smwsp_pkg.sv
// types shared by the static memory access sequencer
package smwsp_pkg;

    typedef enum logic [1:0] {
        SMWSP_IDLE   = 2'b00,
        SMWSP_ACCESS = 2'b01,
        SMWSP_RELOAD = 2'b10
    } smwsp_state_t;

    typedef logic [9:0]  smwsp_len_t;
    typedef logic [25:0] smwsp_addr_t;

endpackage : smwsp_pkg

// file: smwsp_sync.sv
// two-flop synchroniser for the external hold request pin
`timescale 1ns/1ps
`include "smwsp_cfg.svh"

module smwsp_sync (
    input  wire logic clock,
    input  wire logic nrst,
    input  wire logic pin_in,
    output logic      pin_sync
);
    logic meta_r;
    logic meta_nxt;
    logic sync_r;
    logic sync_nxt;

    always_comb begin
        meta_nxt = pin_in;
        sync_nxt = meta_r;
    end

    // reset to the released level so no stall appears out of reset
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            meta_r <= `SMWSP_HOLD_IDLE;
            sync_r <= `SMWSP_HOLD_IDLE;
        end else begin
            meta_r <= meta_nxt;
            sync_r <= sync_nxt;
        end
    end

    assign pin_sync = sync_r;

endmodule : smwsp_sync

// file: smwsp_ctrl.sv
// static memory access sequencer: external wait, slow clock waveforms, page reads
`timescale 1ns/1ps
`include "smwsp_cfg.svh"

module smwsp_ctrl
    import smwsp_pkg::*;
#(
    parameter int NUM_CS = 8
) (
    input  wire logic              clock,
    input  wire logic              nrst,
    input  wire logic              req_valid,
    output logic                   req_ready,
    input  wire logic              req_write,
    input  wire logic [2:0]        req_cs,
    input  wire logic [25:0]       req_addr,
    input  wire logic [1:0]        ext_wait_mode,
    input  wire logic              read_mode,
    input  wire logic              write_mode,
    input  wire logic [5:0]        read_strobe_setup,
    input  wire logic [6:0]        read_strobe_pulse,
    input  wire logic [8:0]        read_total_cycle,
    input  wire logic [5:0]        cs_read_setup,
    input  wire logic [6:0]        cs_read_pulse,
    input  wire logic [5:0]        write_strobe_setup,
    input  wire logic [6:0]        write_strobe_pulse,
    input  wire logic [8:0]        write_total_cycle,
    input  wire logic [5:0]        cs_write_setup,
    input  wire logic [6:0]        cs_write_pulse,
    input  wire logic              page_mode_enable,
    input  wire logic [1:0]        page_size,
    input  wire logic              byte_access_type,
    input  wire logic [1:0]        data_bus_width,
    input  wire logic              slow_clock_mode,
    input  wire logic              cfg_reload,
    input  wire logic              other_access,
    input  wire logic              ext_hold_request_n,
    output logic [NUM_CS-1:0]      chip_select_n,
    output logic                   read_strobe_n,
    output logic                   write_strobe_n,
    output logic                   access_done,
    output logic                   page_hit,
    output logic [4:0]             page_offset,
    output logic                   byte_select_mode,
    output logic                   reload_wait
);

    if (NUM_CS < 1 || NUM_CS > 8) begin : g_bad_cs
        $error("NUM_CS must lie between 1 and 8");
    end

    function automatic smwsp_len_t dec_setup(input logic [5:0] v);
        dec_setup = {2'h0, v[5], 2'h0, v[4:0]};
    endfunction : dec_setup

    function automatic smwsp_len_t dec_pulse(input logic [6:0] v);
        dec_pulse = {1'h0, v[6], 2'h0, v[5:0]};
    endfunction : dec_pulse

    function automatic smwsp_len_t dec_cycle(input logic [8:0] v);
        dec_cycle = {v[8:7], 1'h0, v[6:0]};
    endfunction : dec_cycle

    function automatic logic in_win(input smwsp_len_t c, input smwsp_len_t s,
                                    input smwsp_len_t p);
        in_win = (c >= s) && (c < s + p);
    endfunction : in_win

    // mask of in-page offset bits for the selected page size
    function automatic smwsp_addr_t off_mask(input logic [1:0] ps);
        off_mask = (26'h0000004 << ps) - 26'h0000001;
    endfunction : off_mask

    logic hold_sync;

    smwsp_sync u_sync (
        .clock    (clock),
        .nrst     (nrst),
        .pin_in   (ext_hold_request_n),
        .pin_sync (hold_sync)
    );

    smwsp_state_t      state_r, state_nxt;
    smwsp_len_t        cnt_r, cnt_nxt;
    smwsp_len_t        st_setup_r, st_setup_nxt;
    smwsp_len_t        st_pulse_r, st_pulse_nxt;
    smwsp_len_t        cs_setup_r, cs_setup_nxt;
    smwsp_len_t        cs_pulse_r, cs_pulse_nxt;
    smwsp_len_t        last_r, last_nxt;
    smwsp_len_t        ctl_setup_r, ctl_setup_nxt;
    smwsp_len_t        ctl_end_r, ctl_end_nxt;
    logic [1:0]        wmode_r, wmode_nxt;
    logic              is_wr_r, is_wr_nxt;
    logic              page_rd_r, page_rd_nxt;
    logic [2:0]        cs_idx_r, cs_idx_nxt;
    logic              slow_cur_r, slow_cur_nxt;
    logic              reload_pend_r, reload_pend_nxt;
    logic              pg_valid_r, pg_valid_nxt;
    logic [2:0]        pg_cs_r, pg_cs_nxt;
    smwsp_addr_t       pg_addr_r, pg_addr_nxt;
    logic              page_hit_r, page_hit_nxt;
    logic [4:0]        pg_off_r, pg_off_nxt;
    logic              bat_r, bat_nxt;
    logic              done_r, done_nxt;
    logic [NUM_CS-1:0] cs_n_r, cs_n_nxt;
    logic              rd_n_r, rd_n_nxt;
    logic              wr_n_r, wr_n_nxt;

    logic        in_ctl_pulse;
    logic        hold_on;
    logic        stall;
    logic        start;
    logic        hit_now;
    smwsp_addr_t req_base;
    smwsp_addr_t drop_mask;
    smwsp_len_t  total;
    smwsp_len_t  ss, sp, cs_s, cs_p;

    assign hold_on      = !hold_sync;
    assign in_ctl_pulse = (state_r == SMWSP_ACCESS) && in_win(cnt_r, ctl_setup_r,
                                                              ctl_end_r - ctl_setup_r);
    // wait is only meaningful inside the controlling pulse
    always_comb begin
        stall = 1'b0;
        unique case (wmode_r)
            `SMWSP_WAIT_FROZEN: stall = in_ctl_pulse && hold_on;
            `SMWSP_WAIT_READY:  stall = in_ctl_pulse && hold_on &&
                                        (cnt_r == ctl_end_r - 10'h001);
            default:            stall = 1'b0;
        endcase
    end

    assign req_ready = (state_r == SMWSP_IDLE) && !reload_pend_r &&
                       (slow_clock_mode == slow_cur_r);
    assign start     = req_valid && req_ready;
    assign req_base  = req_addr & ~off_mask(page_size);
    assign hit_now   = pg_valid_r && (pg_cs_r == req_cs) && (pg_addr_r == req_base);
    // 16- and 32-bit buses drop the byte address bits within a word they cannot split
    assign drop_mask = (data_bus_width == `SMWSP_DBW_32) ? 26'h3FFFFFC :
                       (data_bus_width == `SMWSP_DBW_16) ? 26'h3FFFFFE : 26'h3FFFFFF;

    // parameter selection for a new access
    always_comb begin
        if (slow_cur_r && req_write) begin
            ss = `SMWSP_SLOW_WR_SETUP;  sp = `SMWSP_SLOW_WR_PULSE;
            cs_s = `SMWSP_SLOW_CS_WR_SETUP; cs_p = `SMWSP_SLOW_CS_WR_PULSE;
            total = `SMWSP_SLOW_WR_CYCLE;
        end else if (slow_cur_r) begin
            ss = `SMWSP_SLOW_RD_SETUP;  sp = `SMWSP_SLOW_RD_PULSE;
            cs_s = `SMWSP_SLOW_CS_RD_SETUP; cs_p = `SMWSP_SLOW_CS_RD_PULSE;
            total = `SMWSP_SLOW_RD_CYCLE;
        end else if (req_write) begin
            ss = dec_setup(write_strobe_setup); sp = dec_pulse(write_strobe_pulse);
            cs_s = dec_setup(cs_write_setup);   cs_p = dec_pulse(cs_write_pulse);
            total = dec_cycle(write_total_cycle);
        end else if (page_mode_enable) begin
            // both strobes share one window; setup, mode and cycle unused
            ss = `SMWSP_CNT_RESET;
            sp = hit_now ? dec_pulse(read_strobe_pulse)
                         : dec_pulse(cs_read_pulse);
            cs_s = ss;
            cs_p = sp;
            total = sp;
        end else begin
            ss = dec_setup(read_strobe_setup);  sp = dec_pulse(read_strobe_pulse);
            cs_s = dec_setup(cs_read_setup);    cs_p = dec_pulse(cs_read_pulse);
            total = dec_cycle(read_total_cycle);
        end
    end

    always_comb begin
        state_nxt       = state_r;
        cnt_nxt         = cnt_r;
        st_setup_nxt    = st_setup_r;
        st_pulse_nxt    = st_pulse_r;
        cs_setup_nxt    = cs_setup_r;
        cs_pulse_nxt    = cs_pulse_r;
        last_nxt        = last_r;
        ctl_setup_nxt   = ctl_setup_r;
        ctl_end_nxt     = ctl_end_r;
        wmode_nxt       = wmode_r;
        is_wr_nxt       = is_wr_r;
        page_rd_nxt     = page_rd_r;
        cs_idx_nxt      = cs_idx_r;
        slow_cur_nxt    = slow_cur_r;
        reload_pend_nxt = reload_pend_r;
        pg_valid_nxt    = pg_valid_r;
        pg_cs_nxt       = pg_cs_r;
        pg_addr_nxt     = pg_addr_r;
        page_hit_nxt    = page_hit_r;
        pg_off_nxt      = pg_off_r;
        bat_nxt         = bat_r;
        done_nxt        = 1'b0;
        unique case (state_r)
            SMWSP_IDLE: begin
                if (reload_pend_r || (slow_clock_mode != slow_cur_r)) begin
                    state_nxt       = SMWSP_RELOAD;
                    slow_cur_nxt    = slow_clock_mode;
                    reload_pend_nxt = 1'b0;
                end else if (start) begin
                    state_nxt     = SMWSP_ACCESS;
                    cnt_nxt       = `SMWSP_CNT_RESET;
                    st_setup_nxt  = ss;
                    st_pulse_nxt  = sp;
                    cs_setup_nxt  = cs_s;
                    cs_pulse_nxt  = cs_p;
                    // a zero total would wrap to a 1024-cycle access; run it for one cycle
                    last_nxt      = (total == 10'h000) ? 10'h000 : total - 10'h001;
                    is_wr_nxt     = req_write;
                    cs_idx_nxt    = req_cs;
                    page_rd_nxt   = page_mode_enable && !req_write && !slow_cur_r;
                    bat_nxt       = byte_access_type;
                    if ((req_write ? write_mode : read_mode) && !page_rd_nxt) begin
                        ctl_setup_nxt = ss;
                        ctl_end_nxt   = ss + sp;
                    end else begin
                        ctl_setup_nxt = cs_s;
                        ctl_end_nxt   = cs_s + cs_p;
                    end
                    // wait handling has no meaning with fixed or page timings
                    wmode_nxt     = (slow_cur_r || page_rd_nxt) ? `SMWSP_WAIT_OFF
                                                               : ext_wait_mode;
                    if (page_rd_nxt) begin
                        page_hit_nxt = hit_now;
                        pg_valid_nxt = 1'b1;
                        pg_cs_nxt    = req_cs;
                        pg_addr_nxt  = req_base;
                        pg_off_nxt   = 5'(req_addr & off_mask(page_size) & drop_mask);
                    end else begin
                        page_hit_nxt = 1'b0;
                        pg_valid_nxt = 1'b0;
                    end
                end
            end
            SMWSP_ACCESS: begin
                if (!stall) begin
                    if (cnt_r >= last_r) begin
                        state_nxt = SMWSP_IDLE;
                        done_nxt  = 1'b1;
                    end else begin
                        cnt_nxt = cnt_r + 10'h001;
                    end
                end
            end
            SMWSP_RELOAD: begin
                state_nxt    = SMWSP_IDLE;
                pg_valid_nxt = 1'b0;
            end
            default: begin
                state_nxt = SMWSP_IDLE;
            end
        endcase
        // a reload request or intervening access is never lost
        if (cfg_reload) begin
            reload_pend_nxt = 1'b1;
        end
        if (other_access) begin
            pg_valid_nxt = 1'b0;
        end
    end

    // strobes are registered from next count so frozen cycles repeat them
    always_comb begin
        cs_n_nxt = {NUM_CS{1'b1}};
        rd_n_nxt = 1'b1;
        wr_n_nxt = 1'b1;
        if (state_nxt == SMWSP_ACCESS) begin
            if (in_win(cnt_nxt, cs_setup_nxt, cs_pulse_nxt) &&
                (32'(cs_idx_nxt) < NUM_CS)) begin
                cs_n_nxt[cs_idx_nxt] = 1'b0;
            end
            if (in_win(cnt_nxt, st_setup_nxt, st_pulse_nxt)) begin
                rd_n_nxt = is_wr_nxt;
                wr_n_nxt = !is_wr_nxt;
            end
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            state_r       <= SMWSP_IDLE;
            cnt_r         <= `SMWSP_CNT_RESET;
            st_setup_r    <= `SMWSP_CNT_RESET;
            st_pulse_r    <= `SMWSP_CNT_RESET;
            cs_setup_r    <= `SMWSP_CNT_RESET;
            cs_pulse_r    <= `SMWSP_CNT_RESET;
            last_r        <= `SMWSP_CNT_RESET;
            ctl_setup_r   <= `SMWSP_CNT_RESET;
            ctl_end_r     <= `SMWSP_CNT_RESET;
            wmode_r       <= `SMWSP_WAIT_OFF;
            is_wr_r       <= 1'b0;
            page_rd_r     <= 1'b0;
            cs_idx_r      <= `SMWSP_CS_RESET;
            slow_cur_r    <= 1'b0;
            reload_pend_r <= 1'b0;
            pg_valid_r    <= 1'b0;
            pg_cs_r       <= `SMWSP_CS_RESET;
            pg_addr_r     <= `SMWSP_ADDR_RESET;
            page_hit_r    <= 1'b0;
            pg_off_r      <= `SMWSP_OFF_RESET;
            bat_r         <= 1'b0;
            done_r        <= 1'b0;
            cs_n_r        <= {NUM_CS{1'b1}};
            rd_n_r        <= 1'b1;
            wr_n_r        <= 1'b1;
        end else begin
            state_r       <= state_nxt;
            cnt_r         <= cnt_nxt;
            st_setup_r    <= st_setup_nxt;
            st_pulse_r    <= st_pulse_nxt;
            cs_setup_r    <= cs_setup_nxt;
            cs_pulse_r    <= cs_pulse_nxt;
            last_r        <= last_nxt;
            ctl_setup_r   <= ctl_setup_nxt;
            ctl_end_r     <= ctl_end_nxt;
            wmode_r       <= wmode_nxt;
            is_wr_r       <= is_wr_nxt;
            page_rd_r     <= page_rd_nxt;
            cs_idx_r      <= cs_idx_nxt;
            slow_cur_r    <= slow_cur_nxt;
            reload_pend_r <= reload_pend_nxt;
            pg_valid_r    <= pg_valid_nxt;
            pg_cs_r       <= pg_cs_nxt;
            pg_addr_r     <= pg_addr_nxt;
            page_hit_r    <= page_hit_nxt;
            pg_off_r      <= pg_off_nxt;
            bat_r         <= bat_nxt;
            done_r        <= done_nxt;
            cs_n_r        <= cs_n_nxt;
            rd_n_r        <= rd_n_nxt;
            wr_n_r        <= wr_n_nxt;
        end
    end

    assign chip_select_n    = cs_n_r;
    assign read_strobe_n    = rd_n_r;
    assign write_strobe_n   = wr_n_r;
    assign access_done      = done_r;
    assign page_hit         = page_hit_r;
    assign page_offset      = pg_off_r;
    assign byte_select_mode = bat_r;
    assign reload_wait      = (state_r == SMWSP_RELOAD);

    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);

    wait_off_quiet_a: assert property (wmode_r[1] == 1'b0 &&
        state_r == SMWSP_ACCESS && cnt_r < last_r |=> cnt_r == $past(cnt_r) + 10'h001)
        else $error("access held with wait handling off");
    wait_in_pulse_a: assert property (state_r == SMWSP_ACCESS && !in_ctl_pulse &&
        cnt_r < last_r |=> cnt_r == $past(cnt_r) + 10'h001)
        else $error("access held outside controlling pulse");
    frozen_hold_a: assert property (stall && wmode_r == `SMWSP_WAIT_FROZEN |=>
        $stable(cnt_r) && $stable(rd_n_r) && $stable(wr_n_r) && $stable(cs_n_r))
        else $error("frozen access moved");
    ready_last_a: assert property (wmode_r == `SMWSP_WAIT_READY &&
        state_r == SMWSP_ACCESS && cnt_r != ctl_end_r - 10'h001 && cnt_r < last_r
        |=> cnt_r == $past(cnt_r) + 10'h001)
        else $error("ready access held away from last pulse cycle");
    ready_resume_a: assert property ($past(stall) && !stall && state_r == SMWSP_ACCESS
        && cnt_r < last_r |=> cnt_r == $past(cnt_r) + 10'h001)
        else $error("access did not resume");
    slow_read_a: assert property (start && slow_cur_r && !req_write |=>
        rd_n_r && !(&cs_n_r) ##1 !rd_n_r && !(&cs_n_r) ##1 rd_n_r && done_r)
        else $error("slow read waveform wrong");
    slow_write_a: assert property (start && slow_cur_r && req_write |=>
        wr_n_r ##1 !wr_n_r && !(&cs_n_r) ##1 wr_n_r && !(&cs_n_r) ##1 done_r)
        else $error("slow write waveform wrong");
    reload_on_slow_a: assert property (state_r == SMWSP_IDLE &&
        slow_clock_mode != slow_cur_r |=> reload_wait ##1 !reload_wait)
        else $error("missing reload wait state");
    page_hit_a: assert property (start && page_mode_enable && !req_write && !slow_cur_r
        |=> page_hit_r == $past(hit_now))
        else $error("page hit decision wrong");
    page_low_a: assert property (state_r == SMWSP_ACCESS && page_rd_r && st_pulse_r != 10'h000
        |-> !rd_n_r && !(&cs_n_r))
        else $error("page read strobes not low");

    slow_read_c:   cover property (start && slow_cur_r && !req_write);
    page_hit_c:    cover property (start && page_mode_enable && hit_now);
    ready_stall_c: cover property (stall && wmode_r == `SMWSP_WAIT_READY);
    frozen_c:      cover property (stall [*2] ##1 !stall);

endmodule : smwsp_ctrl

// file: smwsp_mem_model.sv
// external memory model that holds the access with its active-low wait pin
`timescale 1ns/1ps

module smwsp_mem_model (
    input  wire logic       clock,
    input  wire logic       nrst,
    input  wire logic       strobe_n,
    input  wire logic [7:0] hold_lat,
    input  wire logic [7:0] hold_len,
    output logic            ext_hold_request_n
);
    logic [7:0] cnt_r;
    logic       prev_r;

    // answers a strobe fall after hold_lat cycles, for hold_len cycles; pulled up when released
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            cnt_r              <= 8'h00;
            prev_r             <= 1'b1;
            ext_hold_request_n <= 1'b1;
        end else begin
            prev_r <= strobe_n;
            if (prev_r && !strobe_n)
                cnt_r <= 8'h01;
            else if (cnt_r != 8'h00 && cnt_r != 8'hFF)
                cnt_r <= cnt_r + 8'h01;
            ext_hold_request_n <= !(hold_len != 8'h00 && cnt_r >= hold_lat &&
                                    cnt_r < hold_lat + hold_len);
        end
    end
endmodule : smwsp_mem_model

// file: tb.sv
// self-checking bench for the static memory access sequencer
`timescale 1ns/1ps

module tb;
    typedef struct {logic [9:0] len; logic [9:0] str; logic [9:0] hit; logic [9:0] off;} smwsp_note_t;
    logic        clock, nrst, req_valid, req_ready, req_write, read_mode, write_mode;
    logic        page_mode_enable, byte_access_type, slow_clock_mode, cfg_reload, other_access;
    logic        ext_hold_request_n, read_strobe_n, write_strobe_n, access_done, page_hit;
    logic        byte_select_mode, reload_wait;
    logic [2:0]  req_cs;
    logic [25:0] req_addr;
    logic [1:0]  ext_wait_mode, page_size, data_bus_width;
    logic [5:0]  read_strobe_setup, cs_read_setup, write_strobe_setup, cs_write_setup;
    logic [6:0]  read_strobe_pulse, cs_read_pulse, write_strobe_pulse, cs_write_pulse;
    logic [8:0]  read_total_cycle, write_total_cycle;
    logic [7:0]  chip_select_n, hold_lat, hold_len;
    logic [4:0]  page_offset;
    int          bad_count, check_count, cyc, start, scnt, ccnt, busy, s, p, c;
    smwsp_note_t q[$];
    smwsp_note_t n;
    // 8-byte pages on a 16-bit bus: offset bit 0 always reads zero
    localparam logic [25:0] PAD [6] = '{26'h10, 26'h13, 26'h17, 26'h18, 26'h19, 26'h1B};
    localparam logic [2:0]  PCS [6] = '{3'h3, 3'h3, 3'h3, 3'h3, 3'h3, 3'h4};
    localparam logic [9:0]  PLEN[6] = '{10'h2, 10'h5, 10'h5, 10'h2, 10'h2, 10'h2};
    localparam logic [9:0]  PHIT[6] = '{10'h0, 10'h1, 10'h1, 10'h0, 10'h0, 10'h0};
    localparam logic [9:0]  POFF[6] = '{10'h0, 10'h2, 10'h6, 10'h0, 10'h0, 10'h2};

    smwsp_ctrl #(.NUM_CS(8)) smwsp_ctrl_i (.clock, .nrst, .req_valid, .req_ready, .req_write,
        .req_cs, .req_addr, .ext_wait_mode, .read_mode, .write_mode, .read_strobe_setup,
        .read_strobe_pulse, .read_total_cycle, .cs_read_setup, .cs_read_pulse,
        .write_strobe_setup, .write_strobe_pulse, .write_total_cycle, .cs_write_setup,
        .cs_write_pulse, .page_mode_enable, .page_size, .byte_access_type, .data_bus_width,
        .slow_clock_mode, .cfg_reload, .other_access, .ext_hold_request_n, .chip_select_n,
        .read_strobe_n, .write_strobe_n, .access_done, .page_hit, .page_offset,
        .byte_select_mode, .reload_wait);
    smwsp_mem_model smwsp_mem_model_i (.clock, .nrst, .strobe_n(read_strobe_n & write_strobe_n),
        .hold_lat, .hold_len, .ext_hold_request_n);

    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    task automatic cmp(input string what, input logic [9:0] exp, input logic [9:0] got);
        if (exp !== 10'h3FF) begin
            check_count++;
            if (got !== exp) begin
                bad_count++;
                $display("BAD %s expected %0d seen %0d", what, exp, got);
            end
        end
    endtask : cmp

    task automatic close_out();
        if (q.size() != 0) bad_count++;
        if (bad_count == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : close_out

    // one request, held until taken, then waits for its completion pulse
    task automatic acc(input logic wr, input logic [2:0] cs, input logic [25:0] a,
                       input logic [9:0] len, str, hit, off, input logic drop);
        int i;
        i = 0;
        q.push_back('{len, str, hit, off});
        req_write <= wr;
        req_cs    <= cs;
        req_addr  <= a;
        req_valid <= 1'b1;
        do @(posedge clock); while (req_ready !== 1'b1 && ++i < 300);
        if (i >= 300) bad_count++;
        req_valid <= 1'b0;
        if (drop) slow_clock_mode <= 1'b0;
        i = 0;
        do @(posedge clock); while (access_done !== 1'b1 && ++i < 300);
        if (i >= 300) bad_count++;
    endtask : acc

    task automatic timing(input logic [5:0] ts, input logic [6:0] tp, input logic [8:0] tc);
        read_strobe_setup  <= ts;
        write_strobe_setup <= ts;
        read_strobe_pulse  <= tp;
        write_strobe_pulse <= tp;
        cs_read_pulse      <= 7'(tc);
        cs_write_pulse     <= 7'(tc);
        read_total_cycle   <= tc;
        write_total_cycle  <= tc;
    endtask : timing

    task automatic reload_chk();
        int i;
        i = 0;
        do @(posedge clock); while (reload_wait !== 1'b1 && ++i < 20);
        cmp("reload", 10'h001, {9'h000, reload_wait});
    endtask : reload_chk

    // the watcher pairs each completion with the oldest note
    always @(posedge clock) begin
        if (access_done === 1'b1 && busy != 0) begin
            n = q.pop_front();
            cmp("length", n.len, 10'(cyc - start - 1));
            cmp("strobe", n.str, scnt[9:0]);
            cmp("select", n.len, ccnt[9:0]);
            cmp("hit", n.hit, {9'h000, page_hit});
            cmp("offset", n.off, {5'h00, page_offset});
            busy = 0;
        end else if (busy != 0) begin
            if ((read_strobe_n & write_strobe_n) === 1'b0) scnt++;
            if ($countones(~chip_select_n) == 1) ccnt++;
        end
        if (req_valid && req_ready === 1'b1) begin
            busy  = 1;
            scnt  = 0;
            ccnt  = 0;
            start = cyc;
        end
        cyc++;
    end

    initial begin
        repeat (5000) @(posedge clock);
        bad_count++;
        close_out();
    end

    initial begin
        {nrst, req_valid, req_write, req_cs, req_addr, ext_wait_mode, page_mode_enable} = '0;
        {page_size, byte_access_type, data_bus_width, slow_clock_mode, cfg_reload} = '0;
        {other_access, hold_lat, hold_len, cs_read_setup, cs_write_setup} = '0;
        {read_mode, write_mode} = 2'h3;
        timing(6'h01, 7'h01, 9'h003);
        void'($urandom(5176));
        repeat (4) @(posedge clock);
        nrst <= 1'b1;
        @(posedge clock);
        repeat (6) begin
            s = $urandom_range(0, 5);
            p = $urandom_range(1, 8);
            c = s + p + $urandom_range(0, 4);
            timing(6'(s), 7'(p), 9'(c));
            acc(1'($urandom), 3'($urandom), 26'($urandom), 10'(c), 10'(p), 10'h3FF, 10'h3FF, 1'b0);
        end
        timing(6'h02, 7'h14, 9'h01E);
        hold_lat <= 8'h02;
        hold_len <= 8'h03;
        // modes off, reserved, frozen, ready: only frozen stretches
        for (int m = 0; m < 4; m++) begin
            ext_wait_mode <= 2'(m);
            acc(1'(m), 3'h1, 26'h40, (m == 2) ? 10'h021 : 10'h01E, (m == 2) ? 10'h017 : 10'h014,
                10'h3FF, 10'h3FF, 1'b0);
        end
        hold_lat <= 8'h19;
        acc(1'b1, 3'h1, 26'h44, 10'h01E, 10'h014, 10'h3FF, 10'h3FF, 1'b0);
        // hold reaches the last pulse cycle: ready mode suspends there
        hold_lat <= 8'h10;
        acc(1'b0, 3'h1, 26'h48, 10'h021, 10'h017, 10'h3FF, 10'h3FF, 1'b0);
        ext_wait_mode   <= 2'h2;
        hold_lat        <= 8'h01;
        slow_clock_mode <= 1'b1;
        reload_chk();
        acc(1'b0, 3'h2, 26'h0, 10'h002, 10'h001, 10'h3FF, 10'h3FF, 1'b0);
        acc(1'b1, 3'h2, 26'h0, 10'h003, 10'h001, 10'h3FF, 10'h3FF, 1'b1);
        reload_chk();
        hold_len         <= 8'h00;
        ext_wait_mode    <= 2'h0;
        page_mode_enable <= 1'b1;
        page_size        <= 2'h1;
        data_bus_width   <= 2'h1;
        read_strobe_pulse <= 7'h05;
        cs_read_pulse    <= 7'h02;
        for (int k = 0; k < 6; k++) begin
            if (k == 4) begin
                other_access <= 1'b1;
                @(posedge clock);
                other_access <= 1'b0;
            end
            byte_access_type <= 1'(k);
            acc(1'b0, PCS[k], PAD[k], PLEN[k], PLEN[k], PHIT[k], POFF[k], 1'b0);
            cmp("byte type", {9'h000, 1'(k)}, {9'h000, byte_select_mode});
        end
        cfg_reload <= 1'b1;
        @(posedge clock);
        cfg_reload <= 1'b0;
        reload_chk();
        // 16-byte pages on a 32-bit bus after the reload dropped tracking
        page_size      <= 2'h2;
        data_bus_width <= 2'h2;
        acc(1'b0, 3'h4, 26'h1B, 10'h002, 10'h002, 10'h000, 10'h008, 1'b0);
        acc(1'b0, 3'h4, 26'h13, 10'h005, 10'h005, 10'h001, 10'h000, 1'b0);
        repeat (2) @(posedge clock);
        close_out();
    end
endmodule : tb
